// >>> sroc_top.sv
// Serial result output controller: framing, polling, addressing, flow control
// Frame: [unit tens, ones] [count hundreds, tens, ones] data CR.
// Unit digits only with multi_drop, count only with attach_count.
// Poll on the line: '@' 'R' 'D' [two unit digits] CR, no spaces.
// A poll that names another unit gets no reply at all.
// A poll with no result held stays pending until one completes.
// Flow codes act at once and never reach the poll parser.
// Host timer runs only while paused; resume clears it, not the error.
// Settings are read live: change them only while rd_ready is high.
// Bytes past the store are taken but not kept, so the host sees a cut result.
// next_read pulses only after a polled frame is fully queued.
`timescale 1ns/10ps
`include "sroc_params.svh"
module sroc_top #(
   parameter int CYC_PER_SEC = `SROC_SECOND_NS / `SROC_CLK_PERIOD_NS
) (
   // Clock, reset, enable
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       ce,
   // Configuration
   input  wire logic       flow_sw,
   input  wire logic [6:0] timeout_s,
   input  wire logic       multi_drop,
   input  wire logic [4:0] unit_no,
   input  wire logic       attach_count,
   input  wire logic       limit_on,
   input  wire logic [9:0] start_pos,
   input  wire logic [9:0] end_pos,
   input  wire logic       polling,
   input  wire logic       err_clear,
   // Reading result stream
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_last,
   output logic            rd_ready,
   // Host receive bytes
   input  wire logic       rx_valid,
   input  wire logic [7:0] rx_data,
   // Host transmit bytes
   output logic            tx_valid,
   output logic [7:0]      tx_data,
   input  wire logic       tx_ready,
   // Status
   output logic            err_out,
   output logic            flow_paused,
   output logic            result_held,
   output logic            next_read
);
   import sroc_pkg::*;

   // Registered state and the value it takes at the next edge
   sroc_state_t r;
   sroc_state_t next_r;

   // Result store, one byte per data position
   logic [7:0]  mem [0:1023];

   // Decoded controls, clamped settings and trim window
   logic        wr_en;
   logic        hold;
   logic        start;
   logic        rx_digit;
   logic [6:0]  rx_val;
   logic [6:0]  tmo;
   logic [4:0]  unit;
   logic [9:0]  first;
   logic [9:0]  lastx;
   logic [9:0]  s_pos;
   logic [9:0]  e_pos;

   sroc_stream_if #(.W(`SROC_FIFO_W)) fs ();

   // Output FIFO; a stalled host backs up into the framer
   sroc_fifo #(.W(`SROC_FIFO_W), .D(`SROC_FIFO_D)) u_fifo (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .s       (fs.fifo)
   );

   // Transmit gating while the host has paused us
   assign hold         = flow_sw && r.paused;
   assign fs.out_ready = tx_ready && !hold;
   assign tx_valid     = fs.out_valid && !hold;
   assign tx_data      = fs.out_data;

   // Status outputs
   assign err_out     = r.err;
   assign flow_paused = r.paused;
   assign result_held = r.has_res;
   assign next_read   = r.next_read;

   // Refuse reading bytes in the start cycle too, else a new first
   // byte would land on the store while the held frame is read out
   assign rd_ready    = (r.sstate == SROC_S_IDLE) && !start;

   // Clamp settings into their legal ranges
   assign tmo = (timeout_s < `SROC_TMO_MIN_S) ? `SROC_TMO_MIN_S :
                (timeout_s > `SROC_TMO_MAX_S) ? `SROC_TMO_MAX_S : timeout_s;
   assign unit = (unit_no < `SROC_UNIT_MIN) ? `SROC_UNIT_MIN :
                 (unit_no > `SROC_UNIT_MAX) ? `SROC_UNIT_MAX : unit_no;

   // Positions below one read as the first character
   assign s_pos = (start_pos < `SROC_POS_MIN) ? `SROC_POS_MIN : start_pos;
   assign e_pos = (end_pos < `SROC_POS_MIN) ? `SROC_POS_MIN : end_pos;

   // Trim window, positions counted from first data character
   assign first = limit_on ? 10'(s_pos - `SROC_POS_MIN) : 10'd0;
   assign lastx = (limit_on && e_pos < r.len) ? e_pos : r.len;

   // Host digit decode
   assign rx_digit = (rx_data >= `SROC_CH_ZERO) && (rx_data <= `SROC_CH_NINE);
   assign rx_val   = 7'(rx_data - `SROC_CH_ZERO);

   // Frame only a complete result, never one still being written
   assign start = (r.sstate == SROC_S_IDLE) && (r.wr_idx == 10'd0) && r.has_res
                  && (r.go || r.poll_pend);

   // Result memory; no reset needed since length gates every read
   always_ff @(posedge clk) begin
      if (ce && wr_en) begin
         mem[r.wr_idx] <= rd_data;
      end
   end

   // Next-state logic for capture, command parse, framing and flow control
   always_comb begin
      next_r           = r;
      next_r.next_read = 1'b0;
      wr_en            = 1'b0;
      fs.in_valid      = 1'b0;
      fs.in_data       = 8'h00;

      // Capture a reading; a new one overwrites the held result
      if (rd_valid && rd_ready) begin
         // Bytes past the store are taken but dropped
         if (r.wr_idx < `SROC_MAX_LEN) begin
            wr_en         = 1'b1;
            next_r.wr_idx = r.wr_idx + 10'd1;
         end
         if (rd_last) begin
            next_r.len     = (r.wr_idx < `SROC_MAX_LEN) ? r.wr_idx + 10'd1 : r.wr_idx;
            next_r.wr_idx  = 10'd0;
            next_r.has_res = 1'b1;
            // Immediate send only with polling and multi-drop both off
            next_r.go      = !polling && !multi_drop;
         end
      end

      // Host bytes: flow codes first, then poll command parse
      if (rx_valid) begin
         if (flow_sw && rx_data == `SROC_CH_PAUSE) begin
            next_r.paused = 1'b1;
         end else if (flow_sw && rx_data == `SROC_CH_RESUME) begin
            next_r.paused = 1'b0;
         end else begin
            unique case (r.cstate)
               SROC_C_AT: begin
                  if (rx_data == `SROC_CH_AT) next_r.cstate = SROC_C_R;
               end
               SROC_C_R: begin
                  if (rx_data == `SROC_CH_R) next_r.cstate = SROC_C_D;
                  else if (rx_data != `SROC_CH_AT) next_r.cstate = SROC_C_AT;
               end
               SROC_C_D: begin
                  if (rx_data == `SROC_CH_D) next_r.cstate = multi_drop ? SROC_C_U1 : SROC_C_FT;
                  else next_r.cstate = (rx_data == `SROC_CH_AT) ? SROC_C_R : SROC_C_AT;
               end
               // Two digits after the command letters name the unit
               SROC_C_U1: begin
                  next_r.unit_rx = 7'(rx_val * 7'd10);
                  next_r.cstate  = rx_digit ? SROC_C_U2 : SROC_C_AT;
               end
               SROC_C_U2: begin
                  next_r.unit_rx = r.unit_rx + rx_val;
                  next_r.cstate  = rx_digit ? SROC_C_FT : SROC_C_AT;
               end
               SROC_C_FT: begin
                  // Wrong unit: drop silently, no reply at all
                  if (rx_data == `SROC_CH_CR && (!multi_drop || r.unit_rx == {2'b00, unit})) begin
                     next_r.poll_pend = 1'b1;
                  end
                  next_r.cstate = SROC_C_AT;
               end
               // Two spare codes of the parser state fall back to idle
               default: begin
                  next_r.cstate = SROC_C_AT;
               end
            endcase
         end
      end

      // Frame builder pushes one byte per accepted FIFO slot
      unique case (r.sstate)
         SROC_S_IDLE: begin
            if (start) begin
               next_r.idx       = first;
               next_r.stop      = lastx;
               next_r.cnt       = (lastx > first) ? 10'(lastx - first) : 10'd0;
               next_r.polled    = r.poll_pend;
               next_r.go        = 1'b0;
               next_r.poll_pend = 1'b0;
               next_r.sstate    = multi_drop ? SROC_S_UNIT_T :
                                  attach_count ? SROC_S_CNT_H : SROC_S_DATA;
            end
         end
         // Unit prefix, tens digit then ones
         SROC_S_UNIT_T: begin
            fs.in_valid = 1'b1;
            fs.in_data  = `SROC_CH_ZERO + 8'(unit / 5'd10);
            if (fs.in_ready) next_r.sstate = SROC_S_UNIT_O;
         end
         SROC_S_UNIT_O: begin
            fs.in_valid = 1'b1;
            fs.in_data  = `SROC_CH_ZERO + 8'(unit % 5'd10);
            if (fs.in_ready) next_r.sstate = attach_count ? SROC_S_CNT_H : SROC_S_DATA;
         end
         // Digit count of the trimmed data, hundreds first
         SROC_S_CNT_H: begin
            fs.in_valid = 1'b1;
            fs.in_data  = `SROC_CH_ZERO + 8'(r.cnt / 10'd100);
            if (fs.in_ready) next_r.sstate = SROC_S_CNT_T;
         end
         SROC_S_CNT_T: begin
            fs.in_valid = 1'b1;
            fs.in_data  = `SROC_CH_ZERO + 8'((r.cnt / 10'd10) % 10'd10);
            if (fs.in_ready) next_r.sstate = SROC_S_CNT_O;
         end
         SROC_S_CNT_O: begin
            fs.in_valid = 1'b1;
            fs.in_data  = `SROC_CH_ZERO + 8'(r.cnt % 10'd10);
            if (fs.in_ready) next_r.sstate = SROC_S_DATA;
         end
         // Data from the trim window, one byte per free slot
         SROC_S_DATA: begin
            if (r.idx >= r.stop) begin
               next_r.sstate = SROC_S_FOOT;
            end else begin
               fs.in_valid = 1'b1;
               fs.in_data  = mem[r.idx];
               if (fs.in_ready) next_r.idx = r.idx + 10'd1;
            end
         end
         // Footer closes the frame and frees the store
         SROC_S_FOOT: begin
            fs.in_valid = 1'b1;
            fs.in_data  = `SROC_CH_CR;
            if (fs.in_ready) begin
               next_r.sstate    = SROC_S_IDLE;
               next_r.has_res   = 1'b0;
               next_r.next_read = r.polled;
            end
         end
      endcase

      // Host silence timer runs only while paused by the host
      // Seconds stop at the limit so a long pause cannot wrap them
      if (hold) begin
         if (r.tick == 28'(CYC_PER_SEC - 1)) begin
            next_r.tick = 28'd0;
            if (r.secs < tmo) next_r.secs = r.secs + 7'd1;
         end else begin
            next_r.tick = r.tick + 28'd1;
         end
      end else begin
         next_r.tick = 28'd0;
         next_r.secs = 7'd0;
      end

      // Error is sticky; a timeout in the clear cycle still wins
      if (err_clear) next_r.err = 1'b0;
      if (hold && r.secs >= tmo) next_r.err = 1'b1;
   end

   // State register; ce low freezes every field
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end
endmodule : sroc_top

// >>> sroc_params.svh
// Constants for the serial result output controller
`ifndef SROC_PARAMS_SVH
`define SROC_PARAMS_SVH

// Clock and timeout timing
`define SROC_CLK_PERIOD_NS 5
`define SROC_SECOND_NS     1000000000
`define SROC_TMO_MIN_S     7'd1
`define SROC_TMO_MAX_S     7'd120
`define SROC_TMO_DEF_S     7'd5

// Unit number range
`define SROC_UNIT_MIN      5'd1
`define SROC_UNIT_MAX      5'd31
`define SROC_UNIT_DEF      5'd1

// Range limit positions
`define SROC_MAX_LEN       10'd999
`define SROC_POS_MIN       10'd1
`define SROC_START_DEF     10'd1
`define SROC_END_DEF       10'd999

// Characters on the line
`define SROC_CH_PAUSE      8'h13
`define SROC_CH_RESUME     8'h11
`define SROC_CH_CR         8'h0d
`define SROC_CH_AT         8'h40
`define SROC_CH_R          8'h52
`define SROC_CH_D          8'h44
`define SROC_CH_ZERO       8'h30
`define SROC_CH_NINE       8'h39

// Output FIFO shape
`define SROC_FIFO_W        8
`define SROC_FIFO_D        16

`endif

// >>> sroc_pkg.sv
// Types for the serial result output controller
package sroc_pkg;

   typedef enum logic [2:0] {
      SROC_S_IDLE, SROC_S_UNIT_T, SROC_S_UNIT_O, SROC_S_CNT_H,
      SROC_S_CNT_T, SROC_S_CNT_O, SROC_S_DATA, SROC_S_FOOT
   } sroc_send_t;

   typedef enum logic [2:0] {
      SROC_C_AT, SROC_C_R, SROC_C_D, SROC_C_U1, SROC_C_U2, SROC_C_FT
   } sroc_cmd_t;

   typedef struct packed {
      sroc_send_t  sstate;
      sroc_cmd_t   cstate;
      logic [9:0]  wr_idx;
      logic [9:0]  len;
      logic [9:0]  idx;
      logic [9:0]  stop;
      logic [9:0]  cnt;
      logic [6:0]  unit_rx;
      logic [6:0]  secs;
      logic [27:0] tick;
      logic        has_res;
      logic        go;
      logic        poll_pend;
      logic        polled;
      logic        paused;
      logic        err;
      logic        next_read;
   } sroc_state_t;

endpackage : sroc_pkg

// >>> sroc_stream_if.sv
// Byte stream carrier between the framer and its output FIFO
`timescale 1ns/10ps
interface sroc_stream_if #(parameter int W = 8);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;

   modport fifo (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data);
   modport user (output in_valid, output in_data, output out_ready,
                 input in_ready, input out_valid, input out_data);
endinterface : sroc_stream_if

// >>> sroc_fifo.sv
// Parameterised byte FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sroc_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   // Stream
   sroc_stream_if.fifo s
);
   import sroc_pkg::*;

   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [CW-1:0]       count;
   } sroc_fifo_state_t;

   sroc_fifo_state_t r;
   sroc_fifo_state_t next_r;
   logic             push;
   logic             pop;

   // Honest flags straight from the fill count
   assign s.in_ready  = (r.count != CW'(D));
   assign s.out_valid = (r.count != '0);
   assign s.out_data  = r.mem[r.rp];

   // Pointer and count update; depth is a power of two so pointers wrap
   always_comb begin
      next_r = r;
      push   = s.in_valid && s.in_ready;
      pop    = s.out_valid && s.out_ready;
      if (push) begin
         next_r.mem[r.wp] = s.in_data;
         next_r.wp        = r.wp + 1'b1;
      end
      if (pop) begin
         next_r.rp = r.rp + 1'b1;
      end
      if (push && !pop) begin
         next_r.count = r.count + 1'b1;
      end else if (pop && !push) begin
         next_r.count = r.count - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end
endmodule : sroc_fifo

// >>> sroc_monitor.sv
// Port-level assertions for the serial result output controller
`timescale 1ns/10ps
module sroc_monitor #(
   parameter int CYC_PER_SEC = 200000000
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       ce,
   // Settings
   input wire logic       flow_sw,
   input wire logic [6:0] timeout_s,
   input wire logic       multi_drop,
   input wire logic       polling,
   input wire logic       err_clear,
   // Streams
   input wire logic       rd_valid,
   input wire logic       rd_last,
   input wire logic       rd_ready,
   input wire logic       rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic       tx_ready,
   // Status
   input wire logic       err_out,
   input wire logic       flow_paused,
   input wire logic       next_read
);
   longint unsigned lim;
   longint unsigned pcnt;
   logic            cr_seen;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Clamped timeout in cycles; wide so a full-rate count cannot wrap
   assign lim = (timeout_s == 7'h00 ? 1 : timeout_s > 7'h78 ? 120 : timeout_s) * longint'(CYC_PER_SEC);
   // Pause length, and whether a request ended since the last frame start
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pcnt    <= 0;
         cr_seen <= 1'b0;
      end else begin
         pcnt    <= (flow_sw && flow_paused) ? pcnt + (ce ? 1 : 0) : 0;
         cr_seen <= (cr_seen && !$fell(rd_ready)) || (ce && rx_valid && rx_data == 8'h0d);
      end
   end
   pause_gate_a:
      assert property (flow_sw && flow_paused |-> !tx_valid) else $error("byte offered while paused");
   pause_set_a:
      assert property (ce && flow_sw && rx_valid && rx_data == 8'h13 |=> flow_paused) else $error("pause missed");
   resume_clr_a:
      assert property (ce && flow_sw && rx_valid && rx_data == 8'h11 |=> !flow_paused) else $error("resume missed");
   err_hold_a:
      assert property (err_out && !err_clear |=> err_out) else $error("error line dropped");
   err_clear_a:
      assert property (ce && err_clear && !(flow_sw && flow_paused) |=> !err_out) else $error("clear ignored");
   tmo_early_a:
      assert property ($rose(err_out) |-> pcnt >= lim) else $error("timeout too early");
   tmo_late_a:
      assert property (pcnt == lim + 5 |-> err_out) else $error("timeout too late");
   immed_send_a:
      assert property (ce && !polling && !multi_drop && rd_valid && rd_ready && rd_last |=> ##[0:2] !rd_ready)
         else $error("result not sent at once");
   poll_only_a:
      assert property ($fell(rd_ready) && (polling || multi_drop) |-> cr_seen) else $error("send without poll");
   next_pulse_a:
      assert property (next_read |-> (polling || multi_drop) ##1 !next_read) else $error("bad next pulse");
   tx_hold_a:
      assert property (tx_valid && !tx_ready && !rx_valid |=> tx_valid && $stable(tx_data))
         else $error("byte withdrawn");
   // Main scenarios reached
   cover property ($rose(err_out));
   cover property (next_read);
   cover property (tx_valid && !tx_ready ##1 tx_valid);
endmodule : sroc_monitor
bind sroc_top sroc_monitor #(.CYC_PER_SEC(CYC_PER_SEC)) u_mon (.*);

// >>> sroc_host.sv
// Host partner model: sends commands and sinks transmitted bytes
`timescale 1ns/10ps
module sroc_host (
   // Clock
   input wire logic       clk,
   // Host to device
   output logic           rx_valid,
   output logic [7:0]     rx_data,
   // Device to host
   input wire logic       tx_valid,
   input wire logic [7:0] tx_data,
   output logic           tx_ready
);
   logic [7:0] got[$];
   logic [1:0] mode = 2'd0;
   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h5a;
      tx_ready = 1'b1;
   end
   // Sink; mode 1 stalls every other cycle, mode 2 stalls always
   always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
   always @(negedge clk) tx_ready <= (mode == 2'd0) || (mode == 2'd1 && !tx_ready);
   // One byte per cycle; released data shows the inverse of the last byte
   task automatic send(input logic [7:0] q[$]);
      foreach (q[i]) begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data  = q[i];
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data  = ~q[q.size()-1];
   endtask : send
   // Data request; unit digits only on a shared line
   task automatic poll(input logic md, input logic [4:0] unit);
      logic [7:0] q[$];
      q = {8'h40, 8'h52, 8'h44};
      if (md) q = {q, 8'h30 + unit / 10, 8'h30 + unit % 10};
      q.push_back(8'h0d);
      send(q);
   endtask : poll
endmodule : sroc_host

// >>> sroc_tb.sv
// Self-checking bench for the serial result output controller
`timescale 1ns/10ps
module sroc_tb;
   logic clk = 1'b0, reset_n = 1'b0, ce = 1'b1, err_clear = 1'b0;
   logic flow_sw = 1'b0, multi_drop = 1'b0, attach_count = 1'b0, limit_on = 1'b0, polling = 1'b0;
   logic [6:0] timeout_s = 7'h05;
   logic [4:0] unit_no   = 5'h01;
   logic [9:0] start_pos = 10'h001, end_pos = 10'h3e7;
   logic       rd_valid = 1'b0, rd_last = 1'b0, rd_ready, rx_valid, tx_valid, tx_ready;
   logic [7:0] rd_data = 8'h00, rx_data, tx_data;
   logic       err_out, flow_paused, result_held, next_read;
   int errors = 0, comparisons = 0, reads = 0;
   sroc_top #(.CYC_PER_SEC(10)) u_dut (.*);
   sroc_host u_host (.*);
   // Clock and pulse counting
   always #2.5 clk = ~clk;
   always @(posedge clk) if (next_read === 1'b1) reads++;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic conclude;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   // Reading bytes, each held until the framer takes it
   task automatic feed(input string s);
      int k;
      foreach (s[i]) begin
         rd_valid = 1'b1;
         rd_data  = s[i];
         rd_last  = (i == s.len() - 1);
         for (k = 0; k < 500 && rd_ready !== 1'b1; k++) @(negedge clk);
         if (k == 500) begin errors++; conclude(); end
         @(negedge clk);
      end
      rd_valid = 1'b0;
      rd_last  = 1'b0;
      rd_data  = ~rd_data;
      // Idle cycle so a following call starts on a fresh edge
      @(negedge clk);
   endtask : feed
   // Wait for a frame, then demand exactly these bytes and no more
   task automatic expect_tx(input string s);
      int k;
      for (k = 0; k < 500 && u_host.got.size() < s.len(); k++) @(negedge clk);
      if (k == 500) begin errors++; conclude(); end
      repeat (30) @(negedge clk);
      check(u_host.got.size(), s.len());
      for (int i = 0; i < s.len() && i < u_host.got.size(); i++) check(u_host.got[i], s[i]);
      u_host.got.delete();
   endtask : expect_tx
   task automatic s_immediate;
      check({rd_ready, tx_valid, err_out, flow_paused, result_held, next_read}, 32'h20);
      u_host.send({8'h13});
      check(flow_paused, 1'b0);
      u_host.mode = 2'd1;
      feed("ABC");
      expect_tx("ABC\015");
      u_host.mode = 2'd2;
      feed("ABCDEFGHIJKLMNOPQRST");
      repeat (40) @(negedge clk);
      check({rd_ready, tx_valid}, 2'b01);
      u_host.mode = 2'd1;
      expect_tx("ABCDEFGHIJKLMNOPQRST\015");
      check(tx_valid, 1'b0);
      u_host.mode = 2'd0;
   endtask : s_immediate
   task automatic s_trim;
      attach_count = 1'b1;
      start_pos = 10'h003;
      end_pos = 10'h004;
      feed("AB");
      expect_tx("002AB\015");
      limit_on = 1'b1;
      start_pos = 10'h002;
      feed("ABCDEF");
      expect_tx("003BCD\015");
      start_pos = 10'h005;
      end_pos = 10'h3e7;
      feed("ABCDEF");
      expect_tx("002EF\015");
      attach_count = 1'b0;
      limit_on = 1'b0;
   endtask : s_trim
   task automatic s_flow;
      int k;
      flow_sw = 1'b1;
      timeout_s = 7'h02;
      u_host.send({8'h13});
      feed("Z");
      repeat (8) @(negedge clk);
      check({flow_paused, tx_valid, u_host.got.size() != 0}, 3'b100);
      u_host.send({8'h11});
      expect_tx("Z\015");
      u_host.send({8'h13});
      for (k = 0; k < 60 && err_out !== 1'b1; k++) @(negedge clk);
      check(k >= 18 && k <= 24, 1'b1);
      repeat (6) @(negedge clk);
      u_host.send({8'h11});
      check(err_out, 1'b1);
      err_clear = 1'b1;
      @(negedge clk);
      err_clear = 1'b0;
      @(negedge clk);
      check(err_out, 1'b0);
      flow_sw = 1'b0;
   endtask : s_flow
   task automatic s_poll;
      polling = 1'b1;
      feed("XY");
      feed("Q");
      check(result_held, 1'b1);
      ce = 1'b0;
      u_host.poll(1'b0, 5'h00);
      repeat (4) @(negedge clk);
      check({result_held, tx_valid, u_host.got.size() != 0}, 3'b100);
      ce = 1'b1;
      expect_tx("");
      u_host.poll(1'b0, 5'h00);
      expect_tx("Q\015");
      check({result_held, reads[7:0]}, 9'h001);
      u_host.poll(1'b0, 5'h00);
      feed("W");
      expect_tx("W\015");
      polling = 1'b0;
   endtask : s_poll
   task automatic s_multi;
      multi_drop = 1'b1;
      unit_no = 5'h05;
      feed("M1");
      expect_tx("");
      u_host.poll(1'b1, 5'h06);
      expect_tx("");
      u_host.poll(1'b1, 5'h05);
      expect_tx("05M1\015");
      unit_no = 5'h1f;
      feed("K");
      u_host.poll(1'b1, 5'h1f);
      expect_tx("31K\015");
      multi_drop = 1'b0;
   endtask : s_multi
   // Reset, then each scenario in turn
   initial begin
      repeat (12) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      s_immediate();
      s_trim();
      s_flow();
      s_poll();
      s_multi();
      conclude();
   end
endmodule : sroc_tb
